/* File: core/access_attribute_unit.sv */
// Address-block attribute unit: window registers, matching, attribute outputs
`timescale 1ns/1ps
module access_attribute_unit
  import attr_pkg::*;
#(
  parameter int RST_SYNC_STAGES = 2
)
(
  input wire logic mclk,
  input wire logic rstn,
  // Control move port
  input wire logic ctl_req,
  input wire logic ctl_write,
  input wire logic ctl_super,
  input wire logic [1:0] ctl_sel,
  input wire logic [WIN_W-1:0] ctl_wdata,
  output logic ctl_ack,
  output logic ctl_priv_err,
  output logic [WIN_W-1:0] ctl_rdata,
  // Default attributes for unmatched accesses
  input wire logic [1:0] dflt_cache_mode,
  input wire logic [1:0] dflt_user_attr,
  // Instruction prefetch lookup
  input wire logic fetch_req,
  input wire logic [ADDR_HI_W-1:0] fetch_addr_hi,
  input wire logic fetch_super,
  output logic fetch_rsp_valid,
  output logic fetch_hit,
  output logic [1:0] fetch_cache_mode,
  output logic [1:0] fetch_user_attr,
  output logic fetch_cacheable,
  output logic fetch_copyback,
  output logic fetch_serialize,
  // Operand lookup
  input wire logic data_req,
  input wire logic [ADDR_HI_W-1:0] data_addr_hi,
  input wire logic data_super,
  input wire logic data_write,
  input wire logic data_rmw,
  output logic data_rsp_valid,
  output logic data_hit,
  output logic [1:0] data_cache_mode,
  output logic [1:0] data_user_attr,
  output logic data_cacheable,
  output logic data_copyback,
  output logic data_serialize,
  output logic data_access_err,
  // External bus transfer and attribute pins
  input wire logic ext_start,
  input wire logic ext_unit,
  input wire logic ext_done,
  output logic user_attr_pin_hi,
  output logic user_attr_pin_lo,
  output logic no_cache_out_pin_n
);

  // Elaboration checks on the parameter and the field layout
  if (RST_SYNC_STAGES < 2) begin : g_bad_sync
    $error("RST_SYNC_STAGES must be at least 2");
  end
  if (BASE_HI - BASE_LO + 1 != ADDR_HI_W) begin : g_bad_base
    $error("Base field width must equal the compared address width");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Attributes of the winning window, or zero when none matches
  function automatic logic [WIN_W-1:0] pick_win(
    input logic hit0,
    input logic hit1,
    input logic [WIN_W-1:0] w0,
    input logic [WIN_W-1:0] w1
  );
    logic [WIN_W-1:0] sel;
    sel = '0;
    if (hit0) begin
      sel = w0;
    end else if (hit1) begin
      sel = w1;
    end
    return sel;
  endfunction

  function automatic logic is_inhibited(input logic [1:0] cm);
    return (cm == CM_INHIBIT_SERIAL) || (cm == CM_INHIBIT);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset synchroniser

  logic [RST_SYNC_STAGES-1:0] rst_sync_q;
  wire logic rst_n_int = rst_sync_q[RST_SYNC_STAGES-1];

  // Assertion acts at once; release waits for the last stage

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= '0;
    end else begin
      rst_sync_q <= {rst_sync_q[RST_SYNC_STAGES-2:0], 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Window registers: 0,1 data side, 2,3 fetch side

  logic [WIN_W-1:0] win_q [4];
  wire logic [3:0] win_hit;

  wire logic ctl_ok = ctl_req & ctl_super;
  wire logic ctl_wr = ctl_ok & ctl_write;
  wire logic [WIN_W-1:0] ctl_wval = ctl_wdata & WIN_WMASK;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_win
      always_ff @(posedge mclk or negedge rst_n_int) begin
        if (!rst_n_int) begin
          win_q[gi] <= WIN_RESET;
        end else if (ctl_wr && (ctl_sel == 2'(gi))) begin
          win_q[gi] <= ctl_wval;
        end
      end

      // Data windows see operand accesses, fetch windows see prefetches
      window_match u_match (
        .win_cfg(win_q[gi]),
        .addr_hi((gi < 2) ? data_addr_hi : fetch_addr_hi),
        .super_acc((gi < 2) ? data_super : fetch_super),
        .hit(win_hit[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Control move port

  // Refused requests and writes return zero
  wire logic [WIN_W-1:0] ctl_rsel = (ctl_ok && !ctl_write) ? win_q[ctl_sel] : '0;

  logic ctl_ack_q;
  logic ctl_priv_err_q;
  logic [WIN_W-1:0] ctl_rdata_q;

  always_ff @(posedge mclk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      ctl_ack_q <= 1'b0;
      ctl_priv_err_q <= 1'b0;
      ctl_rdata_q <= '0;
    end else begin
      ctl_ack_q <= ctl_ok;
      ctl_priv_err_q <= ctl_req & ~ctl_super;
      ctl_rdata_q <= ctl_rsel;
    end
  end

  assign ctl_ack = ctl_ack_q;
  assign ctl_priv_err = ctl_priv_err_q;
  assign ctl_rdata = ctl_rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Attribute selection per unit

  wire logic d_any = win_hit[0] | win_hit[1];
  wire logic f_any = win_hit[2] | win_hit[3];
  wire logic [WIN_W-1:0] d_win = pick_win(win_hit[0], win_hit[1], win_q[0], win_q[1]);
  wire logic [WIN_W-1:0] f_win = pick_win(win_hit[2], win_hit[3], win_q[2], win_q[3]);

  // Unmatched accesses fall back to the default inputs
  wire logic [1:0] d_cm = d_any ? d_win[CM_HI:CM_LO] : dflt_cache_mode;
  wire logic [1:0] f_cm = f_any ? f_win[CM_HI:CM_LO] : dflt_cache_mode;
  wire logic [1:0] d_ua = d_any ? d_win[USER_HI:USER_LO] : dflt_user_attr;
  wire logic [1:0] f_ua = f_any ? f_win[USER_HI:USER_LO] : dflt_user_attr;
  wire logic d_wp = d_any & d_win[WP_BIT];
  wire logic d_err = d_wp & (data_write | data_rmw);

  ////////////////////////////////////////////////////////////////////////////
  // Fetch side response

  logic f_valid_q;
  logic f_hit_q;
  logic [1:0] f_cm_q;
  logic [1:0] f_ua_q;
  logic f_cacheable_q;
  logic f_copyback_q;
  logic f_serialize_q;

  // Cache policy decode of the winning attributes
  wire logic f_cacheable = ~is_inhibited(f_cm);
  wire logic f_copyback = (f_cm == CM_COPYBACK);
  wire logic f_serialize = (f_cm == CM_INHIBIT_SERIAL);

  always_ff @(posedge mclk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      f_valid_q <= 1'b0;
      f_hit_q <= 1'b0;
      f_cm_q <= CM_WRITETHROUGH;
      f_ua_q <= '0;
      f_cacheable_q <= 1'b1;
      f_copyback_q <= 1'b0;
      f_serialize_q <= 1'b0;
    end else begin
      f_valid_q <= fetch_req;
      if (fetch_req) begin
        f_hit_q <= f_any;
        f_cm_q <= f_cm;
        f_ua_q <= f_ua;
        f_cacheable_q <= f_cacheable;
        f_copyback_q <= f_copyback;
        f_serialize_q <= f_serialize;
      end
    end
  end

  assign fetch_rsp_valid = f_valid_q;
  assign fetch_hit = f_hit_q;
  assign fetch_cache_mode = f_cm_q;
  assign fetch_user_attr = f_ua_q;
  assign fetch_cacheable = f_cacheable_q;
  assign fetch_copyback = f_copyback_q;
  assign fetch_serialize = f_serialize_q;

  ////////////////////////////////////////////////////////////////////////////
  // Data side response

  logic d_valid_q;
  logic d_hit_q;
  logic d_err_q;
  logic [1:0] d_cm_q;
  logic [1:0] d_ua_q;
  logic d_cacheable_q;
  logic d_copyback_q;
  logic d_serialize_q;

  // Writethrough vs copyback steers the cache write policy
  wire logic d_cacheable = ~is_inhibited(d_cm);
  wire logic d_copyback = (d_cm == CM_COPYBACK);
  // Pipeline holds order and blocks restart only for serialized blocks
  wire logic d_serialize = (d_cm == CM_INHIBIT_SERIAL);

  always_ff @(posedge mclk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      d_valid_q <= 1'b0;
      d_hit_q <= 1'b0;
      d_err_q <= 1'b0;
      d_cm_q <= CM_WRITETHROUGH;
      d_ua_q <= '0;
      d_cacheable_q <= 1'b1;
      d_copyback_q <= 1'b0;
      d_serialize_q <= 1'b0;
    end else begin
      d_valid_q <= data_req;
      // Abort only writes and read-modify-writes into a protected block
      d_err_q <= data_req & d_err;
      if (data_req) begin
        d_hit_q <= d_any;
        d_cm_q <= d_cm;
        d_ua_q <= d_ua;
        d_cacheable_q <= d_cacheable;
        d_copyback_q <= d_copyback;
        d_serialize_q <= d_serialize;
      end
    end
  end

  assign data_rsp_valid = d_valid_q;
  assign data_hit = d_hit_q;
  assign data_cache_mode = d_cm_q;
  assign data_user_attr = d_ua_q;
  assign data_access_err = d_err_q;
  assign data_cacheable = d_cacheable_q;
  assign data_copyback = d_copyback_q;
  assign data_serialize = d_serialize_q;

  ////////////////////////////////////////////////////////////////////////////
  // External transfer attribute pins

  logic upa_hi_q;
  logic upa_lo_q;
  logic nocache_n_q;

  wire logic [1:0] ext_ua = (ext_unit == UNIT_DATA) ? d_ua_q : f_ua_q;
  wire logic [1:0] ext_cm = (ext_unit == UNIT_DATA) ? d_cm_q : f_cm_q;
  wire logic ext_nocache_n = ~is_inhibited(ext_cm);

  // Pins hold from transfer start until the transfer ends

  always_ff @(posedge mclk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      upa_hi_q <= 1'b0;
      upa_lo_q <= 1'b0;
      nocache_n_q <= 1'b1;
    end else if (ext_start) begin
      upa_hi_q <= ext_ua[1];
      upa_lo_q <= ext_ua[0];
      nocache_n_q <= ext_nocache_n;
    end else if (ext_done) begin
      upa_hi_q <= 1'b0;
      upa_lo_q <= 1'b0;
      nocache_n_q <= 1'b1;
    end
  end

  assign user_attr_pin_hi = upa_hi_q;
  assign user_attr_pin_lo = upa_lo_q;
  assign no_cache_out_pin_n = nocache_n_q;

endmodule

/* File: shared/attr_pkg.sv */
// Constants, field layout and types for the address-block attribute unit
// Operation
// - Reset clears the enable bit of all four window registers.
// - Reset input is asynchronous, synchronised to the clock before use.
// - Four window registers: two for data accesses, two for instruction fetches.
// - Each window is 32 bits: base, mask, enable, privilege, user, cache, protect.
// - A disabled window is ignored; an enabled one takes part in matching.
// - Base field is compared against address bits 31 to 24.
// - Mask bits set to one drop the matching base bit from comparison.
// - Privilege select 00 user only, 01 supervisor only, 1x either.
// - Match needs privilege condition and all unmasked upper bits equal.
// - Address bits below 24 never take part in matching.
// - When both windows of a unit match, the lower-numbered window (0 data, 2 fetch) attributes apply.
// - Write-protected block aborts writes and read-modify-writes with access error.
// - External transfer drives the selected user bits onto the attribute pins.
// - Cache mode 00 writethrough, 01 copyback, 10 inhibit serial, 11 inhibit.
// - Writethrough: reads cached, writes always go to memory and update lines.
// - Copyback: write hits update line and dirty bits; misses fetch then update.
// - Inhibited modes bypass cache, assert no-cache pin, push or invalidate lines.
// - Serialized aligned accesses stay in order, operand reads happen once.
// - Unserialized accesses may reorder reads and refetch operands on restart.
// - Fetch windows serve only prefetches; data windows serve operand accesses.
// - Window registers accessible only by the control move in supervisor mode.
package attr_pkg;

  localparam int WIN_W = 32;
  localparam int ADDR_HI_W = 8;
  localparam int BASE_HI = 31;
  localparam int BASE_LO = 24;
  localparam int MASK_HI = 23;
  localparam int MASK_LO = 16;
  localparam int EN_BIT = 15;
  localparam int PRIV_HI = 14;
  localparam int PRIV_LO = 13;
  localparam int USER_HI = 9;
  localparam int USER_LO = 8;
  localparam int CM_HI = 6;
  localparam int CM_LO = 5;
  localparam int WP_BIT = 2;

  // Writable bits; all others read back as zero
  localparam logic [31:0] WIN_WMASK = 32'hFFFFE364;
  localparam logic [31:0] WIN_RESET = 32'h00000000;

  // Register selectors of the control move port
  localparam logic [1:0] SEL_DATA0 = 2'h0;
  localparam logic [1:0] SEL_DATA1 = 2'h1;
  localparam logic [1:0] SEL_FETCH0 = 2'h2;
  localparam logic [1:0] SEL_FETCH1 = 2'h3;

  localparam logic UNIT_FETCH = 1'h0;
  localparam logic UNIT_DATA = 1'h1;

  typedef enum logic [1:0] {
    CM_WRITETHROUGH = 2'h0,
    CM_COPYBACK = 2'h1,
    CM_INHIBIT_SERIAL = 2'h2,
    CM_INHIBIT = 2'h3
  } cache_mode_type;

endpackage

/* File: core/window_match.sv */
// Match logic of one attribute window register
`timescale 1ns/1ps
module window_match
  import attr_pkg::*;
(
  input wire logic [WIN_W-1:0] win_cfg,
  input wire logic [ADDR_HI_W-1:0] addr_hi,
  input wire logic super_acc,
  output logic hit
);

  wire logic [ADDR_HI_W-1:0] base = win_cfg[BASE_HI:BASE_LO];
  wire logic [ADDR_HI_W-1:0] mask = win_cfg[MASK_HI:MASK_LO];
  wire logic [1:0] priv_sel = win_cfg[PRIV_HI:PRIV_LO];
  wire logic enabled = win_cfg[EN_BIT];

  // 1x ignores privilege, else bit 0 must equal the access privilege
  wire logic priv_ok = priv_sel[1] | (priv_sel[0] == super_acc);

  // Only the upper address byte takes part; masked bits drop out
  wire logic [ADDR_HI_W-1:0] diff = (addr_hi ^ base) & ~mask;

  assign hit = enabled & priv_ok & (diff == '0);

endmodule

/* File: test/access_attribute_unit_checker.sv */
// Port-level assertions for the address-block attribute unit
`timescale 1ns/1ps
module access_attribute_unit_checker
  import attr_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ctl_req,
  input wire logic ctl_super,
  input wire logic ctl_ack,
  input wire logic ctl_priv_err,
  input wire logic [WIN_W-1:0] ctl_rdata,
  input wire logic [1:0] dflt_user_attr,
  input wire logic fetch_req,
  input wire logic fetch_rsp_valid,
  input wire logic data_write,
  input wire logic data_rmw,
  input wire logic data_rsp_valid,
  input wire logic data_hit,
  input wire logic [1:0] data_cache_mode,
  input wire logic [1:0] data_user_attr,
  input wire logic data_access_err,
  input wire logic ext_start,
  input wire logic ext_unit,
  input wire logic user_attr_pin_hi,
  input wire logic user_attr_pin_lo,
  input wire logic no_cache_out_pin_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence data_ext;
    ext_start && ext_unit;
  endsequence
  sequence inhibit_ext;
    data_ext ##0 data_cache_mode[1];
  endsequence
  ctl_grant_a: assert property (ctl_req && ctl_super |=> ctl_ack && !ctl_priv_err)
    else $error("granted access not acknowledged");
  user_refuse_a: assert property (ctl_req && !ctl_super |=> ctl_priv_err && !ctl_ack)
    else $error("user access not refused");
  rsvd_zero_a: assert property (ctl_ack |-> (ctl_rdata & ~WIN_WMASK) == '0)
    else $error("reserved bits not zero");
  fetch_resp_a: assert property (fetch_req |=> fetch_rsp_valid)
    else $error("fetch lookup unanswered");
  prot_abort_a: assert property (data_access_err |-> data_hit && data_rsp_valid
    && ($past(data_write) || $past(data_rmw))) else $error("abort without cause");
  nomatch_dflt_a: assert property (data_rsp_valid && !data_hit |-> !data_access_err
    && data_user_attr == $past(dflt_user_attr)) else $error("default attributes wrong");
  pin_echo_a: assert property (data_ext |=>
    {user_attr_pin_hi, user_attr_pin_lo} == $past(data_user_attr)) else $error("pins wrong");
  inhibit_pin_a: assert property (inhibit_ext |=> !no_cache_out_pin_n)
    else $error("no-cache pin not driven");
endmodule
bind access_attribute_unit access_attribute_unit_checker chk (.mclk, .rstn, .ctl_req,
  .ctl_super, .ctl_ack, .ctl_priv_err, .ctl_rdata, .dflt_user_attr, .fetch_req,
  .fetch_rsp_valid, .data_write, .data_rmw, .data_rsp_valid, .data_hit, .data_cache_mode,
  .data_user_attr, .data_access_err, .ext_start, .ext_unit, .user_attr_pin_hi,
  .user_attr_pin_lo, .no_cache_out_pin_n);

/* File: test/bus_model.sv */
// External bus interface model: one transfer per go request
`timescale 1ns/1ps
module bus_model (
  input wire logic mclk,
  input wire logic go,
  input wire logic unit,
  output logic ext_start,
  output logic ext_unit,
  output logic ext_done
);
  int cnt = 0;
  initial begin
    ext_start = 1'b0;
    ext_unit = 1'b0;
    ext_done = 1'b0;
  end
  always @(posedge mclk) begin
    ext_start <= 1'b0;
    ext_done <= 1'b0;
    if (cnt == 0 && go) begin
      ext_start <= 1'b1;
      ext_unit <= unit;
      cnt <= 4;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      ext_done <= cnt == 1;
    end
  end
endmodule

/* File: test/access_attribute_unit_bench.sv */
// Self-checking bench for the address-block attribute unit
`timescale 1ns/1ps
module access_attribute_unit_bench;
  import attr_pkg::*;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic ctl_req = 1'b0, ctl_write = 1'b0, ctl_super = 1'b0, go = 1'b0, unit = 1'b0;
  logic [1:0] ctl_sel = 2'h0, dflt_cache_mode = 2'h3, dflt_user_attr = 2'h1;
  logic [WIN_W-1:0] ctl_wdata = '0;
  logic fetch_req = 1'b0, fetch_super = 1'b0, data_req = 1'b0, data_super = 1'b0;
  logic data_write = 1'b0, data_rmw = 1'b0;
  logic [ADDR_HI_W-1:0] fetch_addr_hi = '0, data_addr_hi = '0;
  logic ctl_ack, ctl_priv_err, fetch_rsp_valid, fetch_hit, fetch_cacheable, fetch_copyback;
  logic fetch_serialize, data_rsp_valid, data_hit, data_cacheable, data_copyback;
  logic data_serialize, data_access_err, ext_start, ext_unit, ext_done;
  logic user_attr_pin_hi, user_attr_pin_lo, no_cache_out_pin_n;
  logic [WIN_W-1:0] ctl_rdata;
  logic [1:0] fetch_cache_mode, fetch_user_attr, data_cache_mode, data_user_attr;
  int err_count = 0;
  int n_tests = 0;
  always #25 mclk = ~mclk;
  access_attribute_unit dut (.mclk, .rstn, .ctl_req, .ctl_write, .ctl_super, .ctl_sel,
    .ctl_wdata, .ctl_ack, .ctl_priv_err, .ctl_rdata, .dflt_cache_mode, .dflt_user_attr,
    .fetch_req, .fetch_addr_hi, .fetch_super, .fetch_rsp_valid, .fetch_hit, .fetch_cache_mode,
    .fetch_user_attr, .fetch_cacheable, .fetch_copyback, .fetch_serialize, .data_req,
    .data_addr_hi, .data_super, .data_write, .data_rmw, .data_rsp_valid, .data_hit,
    .data_cache_mode, .data_user_attr, .data_cacheable, .data_copyback, .data_serialize,
    .data_access_err, .ext_start, .ext_unit, .ext_done, .user_attr_pin_hi, .user_attr_pin_lo,
    .no_cache_out_pin_n);
  bus_model bfm (.mclk, .go, .unit, .ext_start, .ext_unit, .ext_done);
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic ctl(logic w, logic s, logic [1:0] sel, logic [31:0] wd, logic [31:0] rd);
    @(negedge mclk);
    ctl_req = 1'b1;
    ctl_write = w;
    ctl_super = s;
    ctl_sel = sel;
    ctl_wdata = wd;
    @(negedge mclk);
    ctl_req = 1'b0;
    check("ack", {ctl_ack, ctl_priv_err}, {s, !s});
    check("rdata", ctl_rdata, (s && !w) ? rd : 32'h0);
  endtask
  task automatic look(logic d, logic [7:0] a, logic s, logic [1:0] wm, logic h,
                      logic [1:0] m, logic [1:0] u, logic e);
    @(negedge mclk);
    data_req = d;
    fetch_req = !d;
    data_addr_hi = a;
    fetch_addr_hi = d ? ~a : a;
    data_super = s;
    fetch_super = s;
    {data_rmw, data_write} = wm;
    @(negedge mclk);
    data_req = 1'b0;
    fetch_req = 1'b0;
    check("resp", d ? {data_rsp_valid, data_hit, data_cache_mode, data_user_attr}
      : {fetch_rsp_valid, fetch_hit, fetch_cache_mode, fetch_user_attr}, {1'b1, h, m, u});
    check("flags", d ? {data_cacheable, data_copyback, data_serialize}
      : {fetch_cacheable, fetch_copyback, fetch_serialize}, {!m[1], m == 2'h1, m == 2'h2});
    check("abort", data_access_err, e);
  endtask
  task automatic xfer(logic un, logic [1:0] u, logic nc);
    @(negedge mclk);
    go = 1'b1;
    unit = un;
    @(negedge mclk);
    go = 1'b0;
    @(negedge mclk);
    check("pins", {user_attr_pin_hi, user_attr_pin_lo, no_cache_out_pin_n}, {u, nc});
    for (int i = 0; i < 20 && ext_done !== 1'b1; i++) @(negedge mclk);
    check("done", ext_done, 1'b1);
    @(negedge mclk);
    check("idle", {user_attr_pin_hi, user_attr_pin_lo, no_cache_out_pin_n}, 3'h1);
  endtask
  task automatic do_reset();
    @(negedge mclk);
    rstn = 1'b0;
    repeat (3) @(negedge mclk);
    rstn = 1'b1;
    repeat (3) @(negedge mclk);
  endtask
  task automatic end_sim();
    if (err_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    for (int i = 0; i < 4; i++) ctl(1'b0, 1'b1, i[1:0], '0, 32'h0);
    ctl(1'b1, 1'b1, SEL_DATA0, 32'hFFFFFFFF, '0);
    ctl(1'b1, 1'b0, SEL_DATA0, 32'h0, '0);
    ctl(1'b0, 1'b1, SEL_DATA0, '0, 32'hFFFFE364);
    ctl(1'b1, 1'b1, SEL_DATA0, 32'h120FA244, '0);
    ctl(1'b1, 1'b1, SEL_DATA1, 32'h1003C120, '0);
    look(1'b1, 8'h1A, 1'b1, 2'h0, 1'b1, 2'h2, 2'h2, 1'b0);
    look(1'b1, 8'h1A, 1'b1, 2'h1, 1'b1, 2'h2, 2'h2, 1'b1);
    look(1'b1, 8'h1A, 1'b1, 2'h2, 1'b1, 2'h2, 2'h2, 1'b1);
    xfer(1'b1, 2'h2, 1'b0);
    look(1'b1, 8'h1A, 1'b0, 2'h1, 1'b0, 2'h3, 2'h1, 1'b0);
    look(1'b1, 8'h12, 1'b1, 2'h0, 1'b1, 2'h2, 2'h2, 1'b0);
    look(1'b1, 8'h11, 1'b0, 2'h1, 1'b1, 2'h1, 2'h1, 1'b0);
    xfer(1'b1, 2'h1, 1'b1);
    dflt_cache_mode = 2'h0;
    dflt_user_attr = 2'h2;
    look(1'b1, 8'h22, 1'b1, 2'h1, 1'b0, 2'h0, 2'h2, 1'b0);
    ctl(1'b1, 1'b1, SEL_DATA0, 32'h120F2244, '0);
    look(1'b1, 8'h12, 1'b1, 2'h1, 1'b1, 2'h1, 2'h1, 1'b0);
    look(1'b0, 8'h12, 1'b0, 2'h0, 1'b0, 2'h0, 2'h2, 1'b0);
    ctl(1'b1, 1'b1, SEL_FETCH1, 32'h12008360, '0);
    look(1'b0, 8'h12, 1'b0, 2'h1, 1'b1, 2'h3, 2'h3, 1'b0);
    xfer(1'b0, 2'h3, 1'b0);
    look(1'b0, 8'h12, 1'b1, 2'h0, 1'b0, 2'h0, 2'h2, 1'b0);
    do_reset();
    look(1'b0, 8'h12, 1'b0, 2'h0, 1'b0, 2'h0, 2'h2, 1'b0);
    end_sim();
  end
  initial begin
    #(50 * 2000);
    err_count++;
    end_sim();
  end
endmodule
